// ===== src/pac_map.svh
`ifndef PAC_MAP_SVH
`define PAC_MAP_SVH

// ============================================================
// Result format
`define PAC_RES_W 14
`define PAC_HALF_W 7
`define PAC_MSB_MASK 14'h2000
`define PAC_RES_RST 14'h0000

// ============================================================
// Conversion timing
`define PAC_CONV_TICKS 16
`define PAC_TICK_W 5
`define PAC_CLK_PERIOD_NS 25
`define PAC_OSC_PERIOD_NS 137
`define PAC_OSC_DIV ((`PAC_OSC_PERIOD_NS + `PAC_CLK_PERIOD_NS - 1) / `PAC_CLK_PERIOD_NS)
`define PAC_EOC_PULSE_NS 100
`define PAC_EOC_CYC ((`PAC_EOC_PULSE_NS + `PAC_CLK_PERIOD_NS - 1) / `PAC_CLK_PERIOD_NS)

// ============================================================
// Buffer and pin synchroniser
`define PAC_FIFO_DEPTH 16
`define PAC_PIN_COUNT 5
`define PAC_PIN_RST 5'h07

`endif

// ===== src/pac_pkg.sv
`include "pac_map.svh"

package pac_pkg;
    // ============================================================
    // Types
    typedef enum logic [3:0] {
        PAC_IDLE = 4'h1,
        PAC_CONV = 4'h2,
        PAC_EOCP = 4'h4,
        PAC_POWER_SAVE_N = 4'h8
    } pac_state_t;
    typedef logic [`PAC_RES_W-1:0] pac_code_t;
endpackage

// ===== src/pac_stream_if.sv
`timescale 1ns/1ps
// ============================================================
// Result stream between converter core and buffer
interface pac_stream_if #(parameter int W = 14) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== src/pac_sync2.sv
`timescale 1ns/1ps
// ============================================================
// Two-stage pin synchroniser, one chain per bit
module pac_sync2 #(
    parameter int W = 5,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Pins and synchronised levels
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            logic sync_r;
            // First stage feeds only the second stage
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    meta_r <= RST_VAL[i];
                    sync_r <= RST_VAL[i];
                end else begin
                    meta_r <= asyncIn[i];
                    sync_r <= meta_r;
                end
            end
            assign syncOut[i] = sync_r;
        end
    endgenerate
endmodule // pac_sync2

// ===== src/pac_fifo.sv
`timescale 1ns/1ps
// ============================================================
// Result buffer, registered storage, honest full and empty
module pac_fifo #(
    parameter int W = 14,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Stream sides
    pac_stream_if.snk inS,
    pac_stream_if.src outS
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    wire full = (count_r == (AW+1)'(DEPTH));
    wire push = inS.valid && inS.ready;
    wire pop = outS.valid && outS.ready;

    // Handshake decode
    assign inS.ready = !full;
    assign outS.valid = (count_r != '0);
    assign outS.data = mem[rdPtr_r];

    // Storage needs no reset; occupancy guards it
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_r] <= inS.data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_r + AW'(push);
            rdPtr_r <= rdPtr_r + AW'(pop);
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // pac_fifo

// ===== src/pac_conv_top.sv
`timescale 1ns/1ps
`include "pac_map.svh"
// ============================================================
// Functional notes
// - Result pins driven only while read strobe and select are both low.
// - Device counts as selected only while select is low.
// - Start rising edge puts sampler in hold and begins a conversion.
// - Clock input high at start edge selects external conversion clock.
// - Clock input low at start edge selects internal oscillator.
// - Conversion completes after exactly sixteen selected clock cycles; a full result buffer keeps it in conversion until a word leaves.
// - Standby input high runs normally, low enters power-save standby.
// - Status output shows conversion in progress or conversion finished.
// - Start level at conversion end picks status output behaviour.
// - Result bits 6 to 0 appear on three-state low pins.
// - Bipolar results use two's complement coding.
// - Unipolar results use straight binary coding.
// - Status goes high at start edge, high all conversion, then tracking.
// - Most significant bit on bit 13, descending to bit 0.
module pac_conv_top
    import pac_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Conversion control pins
    input wire logic convertStart,
    input wire logic conversionClockIn,
    input wire logic powerSaveN,
    // Host read strobes
    input wire logic csN,
    input wire logic rdN,
    // Held analog level from the front end, and range coding
    input wire logic [`PAC_RES_W-1:0] sampleLevel,
    input wire logic bipolarMode,
    // Three-state result bus
    output logic [`PAC_HALF_W-1:0] resultHighBits,
    output logic [`PAC_HALF_W-1:0] resultLowBits,
    output logic resultOe,
    // Status pins
    output logic busyEoc,
    output logic trackHoldHold,
    output logic standbyActive
);
    // ============================================================
    // Pin synchronisation
    logic [`PAC_PIN_COUNT-1:0] pinSync;
    pac_sync2 #(
        .W(`PAC_PIN_COUNT),
        .RST_VAL(`PAC_PIN_RST)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .asyncIn({convertStart, conversionClockIn, powerSaveN, csN, rdN}),
        .syncOut(pinSync)
    );
    wire startSync = pinSync[4];
    wire clkSync = pinSync[3];
    wire pwrSync = pinSync[2];
    wire csSync = pinSync[1];
    wire rdSync = pinSync[0];

    // ============================================================
    // State and registers
    pac_state_t state_r;
    pac_state_t state_nxt;
    logic startPrev_r;
    logic clkPrev_r;
    logic extSel_r;
    logic [2:0] divCnt_r;
    logic [`PAC_TICK_W-1:0] tickCnt_r;
    pac_code_t held_r;
    pac_code_t sar_r;
    pac_code_t mask_r;
    logic bipolar_r;
    logic [2:0] eocCnt_r;
    logic status_r;
    logic status_nxt;
    pac_code_t dataOut_r;

    // ============================================================
    // Event decode
    // Internal ticks fall every sixth cycle, so an undisturbed conversion holds
    // for ninety-six cycles plus the finishing edge; a full buffer can only
    // stretch it. External ticks arrive three edges after the pin rises.
    wire startRise = startSync && !startPrev_r;
    wire extRise = clkSync && !clkPrev_r;
    wire intTick = (divCnt_r == 3'(`PAC_OSC_DIV - 1));
    wire tick = extSel_r ? extRise : intTick;
    wire ticksDone = (tickCnt_r == `PAC_TICK_W'(`PAC_CONV_TICKS));
    wire inConv = (state_r == PAC_CONV);
    wire inStby = (state_r == PAC_POWER_SAVE_N);
    wire canStart = (state_r == PAC_IDLE) || (state_r == PAC_EOCP);
    wire accept = canStart && pwrSync && startRise;
    wire eocDone = (eocCnt_r == 3'(`PAC_EOC_CYC - 1));

    // Result buffer links
    pac_stream_if #(.W(`PAC_RES_W)) coreS ();
    pac_stream_if #(.W(`PAC_RES_W)) readS ();
    wire finish = inConv && pwrSync && ticksDone && coreS.ready;

    // ============================================================
    // Successive approximation trial, one bit per tick after the first
    wire pac_code_t trialCode = sar_r | mask_r;
    wire trialKeep = (trialCode <= held_r);
    wire trialStep = inConv && tick && !ticksDone && (tickCnt_r != '0) && (mask_r != '0);

    // Output coding: flip the sign bit for offset-to-two's-complement
    wire pac_code_t codedResult = bipolar_r ? {~sar_r[`PAC_RES_W-1], sar_r[`PAC_RES_W-2:0]}
                                            : sar_r;

    // Core pushes its result; a full buffer stalls the end of conversion
    assign coreS.valid = inConv && pwrSync && ticksDone;
    assign coreS.data = codedResult;

    pac_fifo #(
        .W(`PAC_RES_W),
        .DEPTH(`PAC_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .inS(coreS),
        .outS(readS)
    );

    // ============================================================
    // Host read decode
    wire selected = !csSync;
    wire readActive = selected && !rdSync;
    // Output register never changes under a read, so no torn word
    assign readS.ready = !readActive;
    wire resultLoad = readS.valid && readS.ready;

    // ============================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        status_nxt = status_r;
        case (state_r)
            PAC_IDLE: begin
                if (!pwrSync) begin
                    state_nxt = PAC_POWER_SAVE_N;
                end else if (startRise) begin
                    state_nxt = PAC_CONV;
                    status_nxt = 1'b1;
                end
            end
            PAC_CONV: begin
                if (!pwrSync) begin
                    state_nxt = PAC_POWER_SAVE_N;
                    status_nxt = 1'b0;
                end else if (finish) begin
                    // Start still high: busy mode; low: end-of-conversion pulse
                    state_nxt = startSync ? PAC_IDLE : PAC_EOCP;
                    status_nxt = 1'b0;
                end
            end
            PAC_EOCP: begin
                if (!pwrSync) begin
                    state_nxt = PAC_POWER_SAVE_N;
                    status_nxt = 1'b0;
                end else if (startRise) begin
                    state_nxt = PAC_CONV;
                    status_nxt = 1'b1;
                end else if (eocDone) begin
                    state_nxt = PAC_IDLE;
                    status_nxt = 1'b1;
                end
            end
            PAC_POWER_SAVE_N: begin
                if (pwrSync) begin
                    state_nxt = PAC_IDLE;
                end
            end
            default: begin
                state_nxt = PAC_IDLE;
                status_nxt = 1'b0;
            end
        endcase
    end

    // State, status and edge history
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r <= PAC_IDLE;
            status_r <= 1'b0;
            startPrev_r <= 1'b0;
            clkPrev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            status_r <= status_nxt;
            startPrev_r <= startSync;
            clkPrev_r <= clkSync;
        end
    end

    // Clock source and range latched at the start edge
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            extSel_r <= 1'b0;
            bipolar_r <= 1'b0;
            held_r <= `PAC_RES_RST;
        end else if (accept) begin
            extSel_r <= clkSync;
            bipolar_r <= bipolarMode;
            held_r <= sampleLevel;
        end
    end

    // Internal oscillator divider; idles in standby to save power
    always_ff @(posedge ref_clk) begin
        if (!rstn || accept || !inConv || intTick) begin
            divCnt_r <= 3'h0;
        end else begin
            divCnt_r <= divCnt_r + 3'h1;
        end
    end

    // Tick counter saturates at sixteen until the next accepted start clears it
    always_ff @(posedge ref_clk) begin
        if (!rstn || accept) begin
            tickCnt_r <= '0;
        end else if (inConv && tick && !ticksDone) begin
            tickCnt_r <= tickCnt_r + `PAC_TICK_W'(1);
        end
    end

    // Approximation register, MSB trial first
    always_ff @(posedge ref_clk) begin
        if (!rstn || accept) begin
            sar_r <= `PAC_RES_RST;
            mask_r <= `PAC_MSB_MASK;
        end else if (trialStep) begin
            sar_r <= trialKeep ? trialCode : sar_r;
            mask_r <= mask_r >> 1;
        end
    end

    // End-of-conversion pulse width
    always_ff @(posedge ref_clk) begin
        if (!rstn || state_r != PAC_EOCP) begin
            eocCnt_r <= 3'h0;
        end else begin
            eocCnt_r <= eocCnt_r + 3'h1;
        end
    end

    // Readable result, updated only between reads
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dataOut_r <= `PAC_RES_RST;
        end else if (resultLoad) begin
            dataOut_r <= readS.data;
        end
    end

    // ============================================================
    // Output pins
    assign resultHighBits = dataOut_r[`PAC_RES_W-1:`PAC_HALF_W];
    assign resultLowBits = dataOut_r[`PAC_HALF_W-1:0];
    assign resultOe = readActive;
    assign busyEoc = status_r;
    assign trackHoldHold = inConv;
    assign standbyActive = inStby;

    // ============================================================
    // Checks
    localparam int INT_CYC = `PAC_CONV_TICKS * `PAC_OSC_DIV;
    logic [7:0] convCycles_r;
    always_ff @(posedge ref_clk) begin
        if (!rstn || !inConv) begin
            convCycles_r <= 8'h00;
        end else if (convCycles_r != 8'hFF) begin
            convCycles_r <= convCycles_r + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Strobes reach the bus two edges after the pins, through the synchroniser
    oe_gate_a: assert property (($past(csN, 2) || $past(rdN, 2)) |-> !resultOe)
        else $error("result bus driven while not read");
    sel_read_a: assert property ((!$past(csN, 2) && !$past(rdN, 2)) |-> resultOe)
        else $error("selected read left bus undriven");

    // Start, clock source and conversion length
    start_hold_a: assert property (accept |=> trackHoldHold && busyEoc)
        else $error("start edge did not enter hold");
    clk_select_a: assert property (accept |=> extSel_r == $past(clkSync))
        else $error("clock source not latched at start");
    ext_hold_a: assert property ((inConv && extSel_r && !extRise)
        |=> $stable(tickCnt_r))
        else $error("external conversion ticked without a clock edge");
    int_length_a: assert property ((finish && !extSel_r) |-> convCycles_r >= INT_CYC)
        else $error("internal conversion too short");
    int_ignore_a: assert property ((inConv && !extSel_r && !intTick)
        |=> $stable(tickCnt_r))
        else $error("internal conversion ticked off the oscillator");
    tick_count_a: assert property ($fell(trackHoldHold) && pwrSync
        |-> $past(tickCnt_r) == `PAC_TICK_W'(`PAC_CONV_TICKS))
        else $error("conversion ended off sixteen ticks");
    int_exact_a: assert property (($rose(ticksDone) && !extSel_r)
        |-> convCycles_r == 8'(INT_CYC))
        else $error("internal conversion not ninety-six cycles");

    // Standby and status behaviour
    standby_a: assert property (!pwrSync |=> standbyActive && !trackHoldHold)
        else $error("standby input ignored");
    standby_exit_a: assert property ((standbyActive && pwrSync) |=> !standbyActive)
        else $error("standby held after the input returned high");
    eoc_idle_a: assert property ((state_r == PAC_IDLE && $past(state_r) == PAC_EOCP)
        |-> busyEoc)
        else $error("status low after end pulse");
    busy_mode_a: assert property ((finish && startSync) |=> !busyEoc [*2])
        else $error("busy mode status not low after end");
    // A fresh start may legally cut the end pulse short
    eoc_mode_a: assert property ((finish && !startSync && pwrSync)
        |=> (!busyEoc || trackHoldHold) [*4]
        ##1 (busyEoc || trackHoldHold || standbyActive))
        else $error("end pulse width wrong");
    busy_hold_a: assert property (trackHoldHold |-> busyEoc)
        else $error("status low during conversion");
    hold_release_a: assert property ($fell(trackHoldHold) |-> !busyEoc)
        else $error("status high after hold released");

    // Coding, bit order and buffering
    coding_a: assert property ((coreS.valid && bipolar_r)
        |-> coreS.data == (held_r ^ `PAC_MSB_MASK))
        else $error("bipolar coding wrong");
    unipolar_a: assert property ((coreS.valid && !bipolar_r)
        |-> coreS.data == held_r)
        else $error("unipolar coding wrong");
    trial_start_a: assert property (accept
        |=> mask_r == `PAC_MSB_MASK && sar_r == `PAC_RES_RST)
        else $error("approximation did not start at the top bit");
    stall_hold_a: assert property ((inConv && pwrSync && ticksDone && !coreS.ready)
        |=> trackHoldHold)
        else $error("full buffer lost a finished word");
    keep_result_a: assert property (!resultLoad |=> $stable(dataOut_r))
        else $error("result changed without new word");

    // ============================================================
    // Coverage
    int_conv_c: cover property (finish && !extSel_r);
    ext_conv_c: cover property (finish && extSel_r);
    eoc_pulse_c: cover property (state_r == PAC_EOCP && eocDone);
    stall_c: cover property (coreS.valid && !coreS.ready);
    read_c: cover property (resultOe && readS.valid);
endmodule // pac_conv_top

// ===== verif/pac_host_model.sv
`timescale 1ns/1ps
`include "pac_map.svh"
// ============================================================
// Host processor on the three-state result bus
module pac_host_model (
    // Clock
    input wire logic ref_clk,
    // Result bus and status from the converter
    input wire logic [`PAC_HALF_W-1:0] resultHighBits,
    input wire logic [`PAC_HALF_W-1:0] resultLowBits,
    input wire logic resultOe,
    input wire logic trackHoldHold,
    // Read strobes
    output logic csN,
    output logic rdN
);
    logic [`PAC_RES_W-1:0] busLast = 14'h0000;
    logic [`PAC_RES_W-1:0] busLevel;

    // Floating bus shows the inverse of the last word, so stale data never matches
    assign busLevel = resultOe ? {resultHighBits, resultLowBits} : ~busLast;

    // Remember what was last driven
    always @(posedge ref_clk) begin
        if (resultOe) begin
            busLast <= busLevel;
        end
    end

    // Strobes idle high
    initial begin
        csN = 1'b1;
        rdN = 1'b1;
    end

    // Both strobes change together just after an edge
    task automatic setStrobes(input logic cs, input logic rd);
        @(posedge ref_clk);
        csN <= cs;
        rdN <= rd;
    endtask

    // One read cycle; strobes held until the bus is seen driven
    task automatic readWord(output logic [`PAC_RES_W-1:0] word, output bit ok);
        int n;
        n = 0;
        // Reads during a conversion degrade the sample
        while (trackHoldHold === 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        setStrobes(1'b0, 1'b0);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (resultOe !== 1'b1 && n < 8);
        ok = (resultOe === 1'b1);
        word = busLevel;
        csN <= 1'b1;
        rdN <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
endmodule // pac_host_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`include "pac_map.svh"
// ============================================================
// Self-checking bench for the conversion interface
module tb_top;
    import pac_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic convertStart = 1'b0;
    logic conversionClockIn = 1'b0;
    logic powerSaveN = 1'b1;
    logic bipolarMode = 1'b0;
    logic csN;
    logic rdN;
    pac_code_t sampleLevel = 14'h0000;
    logic [`PAC_HALF_W-1:0] resultHighBits;
    logic [`PAC_HALF_W-1:0] resultLowBits;
    logic resultOe;
    logic busyEoc;
    logic trackHoldHold;
    logic standbyActive;
    int errCount = 0;
    int totalChecks = 0;
    int cycleCount = 0;

    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    pac_conv_top dut (.ref_clk(ref_clk), .rstn(rstn), .convertStart(convertStart),
        .conversionClockIn(conversionClockIn), .powerSaveN(powerSaveN), .csN(csN), .rdN(rdN),
        .sampleLevel(sampleLevel), .bipolarMode(bipolarMode), .resultHighBits(resultHighBits),
        .resultLowBits(resultLowBits), .resultOe(resultOe), .busyEoc(busyEoc),
        .trackHoldHold(trackHoldHold), .standbyActive(standbyActive));

    pac_host_model host (.ref_clk(ref_clk), .resultHighBits(resultHighBits),
        .resultLowBits(resultLowBits), .resultOe(resultOe), .trackHoldHold(trackHoldHold),
        .csN(csN), .rdN(rdN));

    // ============================================================
    // Verdict and comparisons
    task automatic printVerdict();
        if (errCount == 0 && totalChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic checkWord(input pac_code_t got, input pac_code_t exp);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp);
        checkWord({13'h0000, got}, {13'h0000, exp});
    endtask

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge ref_clk) begin
        cycleCount++;
        if (cycleCount == 12000) begin
            errCount++;
            printVerdict();
        end
    end

    // ============================================================
    // Helpers
    task automatic waitCycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Clock level set one edge ahead so both synchronisers agree at the start edge
    task automatic startConv(input logic ext, input logic keep);
        int n;
        n = 0;
        @(posedge ref_clk);
        conversionClockIn <= ext;
        @(posedge ref_clk);
        convertStart <= 1'b1;
        while (trackHoldHold !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            n++;
        end
        checkBit(trackHoldHold, 1'b1);
        checkBit(busyEoc, 1'b1);
        if (!keep) begin
            convertStart <= 1'b0;
        end
    endtask

    task automatic waitHoldLow(output int n);
        n = 0;
        while (trackHoldHold === 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    task automatic readCheck(input pac_code_t exp);
        pac_code_t word;
        bit ok;
        host.readWord(word, ok);
        checkBit(ok, 1'b1);
        checkWord(word, exp);
    endtask

    // ============================================================
    // Scenarios
    task automatic resetCheck();
        checkBit(resultOe, 1'b0);
        checkBit(busyEoc, 1'b0);
        checkBit(trackHoldHold, 1'b0);
        checkBit(standbyActive, 1'b0);
    endtask

    // Internal oscillator, start low at the end: end-of-conversion pulse
    task automatic convInternal(input pac_code_t level, input logic bip, input pac_code_t exp);
        int n;
        @(posedge ref_clk);
        sampleLevel <= level;
        bipolarMode <= bip;
        startConv(1'b0, 1'b0);
        waitHoldLow(n);
        checkWord(14'(n), 14'(`PAC_CONV_TICKS * `PAC_OSC_DIV + 1));
        checkBit(busyEoc, 1'b0);
        waitCycles(3);
        checkBit(busyEoc, 1'b0);
        waitCycles(1);
        checkBit(busyEoc, 1'b1);
        readCheck(exp);
    endtask

    // Start still high at the end: status stays low
    task automatic convBusyMode();
        int n;
        @(posedge ref_clk);
        sampleLevel <= 14'h0F0F;
        bipolarMode <= 1'b0;
        startConv(1'b0, 1'b1);
        waitHoldLow(n);
        for (int i = 0; i < 8; i++) begin
            checkBit(busyEoc, 1'b0);
            @(posedge ref_clk);
        end
        convertStart <= 1'b0;
        readCheck(14'h0F0F);
    endtask

    // External clock: 3 cycles high, 2 low, sixteen rising edges
    task automatic convExternal();
        int n;
        @(posedge ref_clk);
        sampleLevel <= 14'h1234;
        startConv(1'b1, 1'b0);
        waitCycles(6);
        for (int i = 0; i < 16; i++) begin
            conversionClockIn <= 1'b0;
            waitCycles(2);
            if (i == 15) begin
                checkBit(trackHoldHold, 1'b1);
            end
            conversionClockIn <= 1'b1;
            waitCycles(3);
        end
        waitHoldLow(n);
        checkBit(n <= 4, 1'b1);
        conversionClockIn <= 1'b0;
        waitCycles(6);
        readCheck(14'h1234);
    endtask

    // Standby aborts a running conversion, keeps the old word, refuses a start edge
    task automatic standbyCheck();
        @(posedge ref_clk);
        sampleLevel <= 14'h3C3C;
        startConv(1'b0, 1'b0);
        waitCycles(20);
        powerSaveN <= 1'b0;
        waitCycles(5);
        checkBit(standbyActive, 1'b1);
        checkBit(trackHoldHold, 1'b0);
        checkBit(busyEoc, 1'b0);
        convertStart <= 1'b1;
        waitCycles(6);
        checkBit(trackHoldHold, 1'b0);
        convertStart <= 1'b0;
        powerSaveN <= 1'b1;
        waitCycles(5);
        checkBit(standbyActive, 1'b0);
        readCheck(14'h1234);
    endtask

    // One strobe alone never drives the bus
    task automatic strobeCheck();
        host.setStrobes(1'b1, 1'b0);
        waitCycles(5);
        checkBit(resultOe, 1'b0);
        host.setStrobes(1'b0, 1'b1);
        waitCycles(5);
        checkBit(resultOe, 1'b0);
        host.setStrobes(1'b1, 1'b1);
        waitCycles(4);
    endtask

    // Frozen read fills the buffer; the seventeenth conversion stalls, then the
    // buffer drains into the result register, which ends on the newest word
    task automatic fifoFill();
        int n;
        host.setStrobes(1'b0, 1'b0);
        waitCycles(4);
        checkBit(resultOe, 1'b1);
        for (int i = 0; i < 17; i++) begin
            @(posedge ref_clk);
            sampleLevel <= 14'(i * 14'h0357);
            startConv(1'b0, 1'b0);
            waitHoldLow(n);
            waitCycles(6);
        end
        checkBit(trackHoldHold, 1'b1);
        checkWord({resultHighBits, resultLowBits}, 14'h1234);
        host.setStrobes(1'b1, 1'b1);
        waitHoldLow(n);
        checkBit(busyEoc, 1'b0);
        waitCycles(24);
        for (int i = 0; i < 17; i++) begin
            readCheck(14'(16 * 14'h0357));
        end
        readCheck(14'(16 * 14'h0357));
    endtask

    // ============================================================
    // Main sequence
    initial begin
        waitCycles(8);
        rstn <= 1'b1;
        waitCycles(6);
        resetCheck();
        convInternal(14'h0000, 1'b0, 14'h0000);
        convInternal(14'h0001, 1'b0, 14'h0001);
        convInternal(14'h2000, 1'b1, 14'h0000);
        convInternal(14'h1FFF, 1'b1, 14'h3FFF);
        convInternal(14'h2A55, 1'b0, 14'h2A55);
        convBusyMode();
        convExternal();
        standbyCheck();
        strobeCheck();
        fifoFill();
        printVerdict();
    end
endmodule // tb_top
